/* logic/acs_bus_if.sv */
// i/o register bus joining the cpu side to the converter control
`timescale 1ns/1ps
interface acs_bus_if;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic wr;
   logic rd;
   logic [7:0] rdata;
   logic irq;
   logic irq_ack;
   modport dev (input addr, input wdata, input wr, input rd, input irq_ack,
      output rdata, output irq);
   modport host (output addr, output wdata, output wr, output rd, output irq_ack,
      input rdata, input irq);
endinterface

/* logic/acs_device.sv */
// converter control sequencer: register file, sequencing and result latch
// Behaviour
// RULE1: temperature code routes and enables the sensor
// RULE2: software uses internal reference, single mode
// RULE3: reference field decodes supply, external, internal
// RULE4: reference change waits for running conversion
// RULE5: reference change makes next conversion long
// RULE6: channel field decodes inputs, ground, bandgap, sensor
// RULE7: channel change waits for running conversion
// RULE8: software writes zero to touch bits
// RULE9: enable on; disable aborts conversion
// RULE10: start bit launches single or first conversion
// RULE11: first conversion after enable lasts 25
// RULE12: start reads busy; writing zero ignored
// RULE13: auto trigger starts on rising trigger edge
// RULE14: flag sets when result registers update
// RULE15: irq needs flag, local and global enable
// RULE16: flag clears on vector or written one
// RULE17: software avoids read-modify-write on control
// RULE18: prescaler divides by 2 up to 128
// RULE19: software waits 1ms after internal reference
// RULE20: software forces long conversion on changes
// RULE21: low byte read freezes result until high
// RULE22: free running code gives no trigger edge
// RULE23: left adjust changes presentation at once
// RULE24: analog core stubbed, result at count end
`timescale 1ns/1ps
module acs_device (
   input wire logic I_CLK,
   input wire logic I_RST_B,
   acs_bus_if.dev bus,
   input wire logic I_GLOBAL_IRQ_ON,
   input wire logic I_TRIGGER,
   input wire logic [9:0] I_ANALOG_SAMPLE,
   output logic [1:0] O_REF_SEL,
   output logic O_REF_PIN_CONNECT,
   output logic [3:0] O_CHANNEL_SEL,
   output logic O_CHANNEL_VALID,
   output logic O_TEMP_SENSOR_ON,
   output logic O_CONVERTER_POWERED,
   output logic O_BUSY
);
   acs_pkg::acs_state_t state_ff;
   logic [7:0] mux_ff;
   logic [7:0] ctrl_b_ff;
   logic [1:0] ref_act_ff;
   logic [3:0] ch_act_ff;
   logic on_ff, auto_ff, flag_ff, irq_on_ff;
   logic [2:0] pre_ff;
   logic need_long_ff;
   logic [4:0] cyc_ff;
   logic [9:0] res_ff;
   logic [9:0] core_ff;
   logic frozen_ff;
   logic trg_s1_ff, trg_s2_ff, trg_d_ff;
   logic tick, wr_ctrl, wr_mux, start_req, trig_edge, done, busy, launch;
   logic [15:0] shown;
   assign wr_ctrl = bus.wr && bus.addr == acs_pkg::OFS_CTRL;
   assign wr_mux = bus.wr && bus.addr == acs_pkg::OFS_MUX;
   assign busy = state_ff == acs_pkg::ST_CONV;
   assign done = busy && tick && cyc_ff == 5'h01;
   acs_prescaler u_pre (
      .i_clk(I_CLK),
      .i_rst_b(I_RST_B),
      .i_run(busy),
      .i_sel(pre_ff),
      .o_tick(tick)
   );
   // trigger pin crosses in from outside, so two flops first
   always_ff @(posedge I_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         trg_s1_ff <= 1'b0;
         trg_s2_ff <= 1'b0;
         trg_d_ff <= 1'b0;
      end else begin
         trg_s1_ff <= I_TRIGGER;
         trg_s2_ff <= trg_s1_ff;
         trg_d_ff <= trg_s2_ff;
      end
   end
   // free running re-triggers from its done state, never from a code switch;
   // the done strobe itself falls while still busy and would be lost
   always_comb begin
      if (ctrl_b_ff[2:0] == acs_pkg::TRIG_FREE) begin
         trig_edge = state_ff == acs_pkg::ST_DONE; // RULE22
      end else begin
         trig_edge = trg_s2_ff && !trg_d_ff; // RULE13
      end
   end
   assign start_req = (wr_ctrl && bus.wdata[acs_pkg::B_START]) || (auto_ff && trig_edge);
   // launch only when not busy; a disabling write always wins over a start
   assign launch = !busy && start_req && (wr_ctrl ? bus.wdata[acs_pkg::B_ON] : on_ff);
   // control register bits written by software
   always_ff @(posedge I_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         on_ff <= 1'b0;
         auto_ff <= 1'b0;
         irq_on_ff <= 1'b0;
         pre_ff <= 3'h0;
         ctrl_b_ff <= acs_pkg::RST_BYTE;
         mux_ff <= acs_pkg::RST_BYTE;
      end else begin
         if (wr_ctrl) begin
            on_ff <= bus.wdata[acs_pkg::B_ON]; // RULE9
            auto_ff <= bus.wdata[acs_pkg::B_AUTO];
            irq_on_ff <= bus.wdata[acs_pkg::B_IRQ_ON];
            pre_ff <= bus.wdata[2:0];
         end
         if (bus.wr && bus.addr == acs_pkg::OFS_CTRL_B) begin
            ctrl_b_ff <= {4'h0, bus.wdata[3:0]};
         end
         if (wr_mux) begin
            mux_ff <= bus.wdata;
         end
      end
   end
   // sequencer; a start while busy is ignored, writing zero to the start bit never stops it
   always_ff @(posedge I_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         state_ff <= acs_pkg::ST_IDLE;
         cyc_ff <= 5'h00;
      end else if (wr_ctrl && !bus.wdata[acs_pkg::B_ON]) begin
         state_ff <= acs_pkg::ST_IDLE; // RULE9
         cyc_ff <= 5'h00;
      end else begin
         unique case (state_ff)
            acs_pkg::ST_IDLE, acs_pkg::ST_DONE: begin
               state_ff <= acs_pkg::ST_IDLE;
               if (launch) begin
                  state_ff <= acs_pkg::ST_CONV; // RULE10
                  cyc_ff <= (need_long_ff || !on_ff) ? acs_pkg::CYC_LONG
                     : acs_pkg::CYC_NORMAL; // RULE11 RULE5
               end
            end
            acs_pkg::ST_CONV: begin
               if (tick) begin
                  cyc_ff <= cyc_ff - 5'h01;
                  if (cyc_ff == 5'h01) begin
                     state_ff <= acs_pkg::ST_DONE;
                  end
               end
            end
            default: state_ff <= acs_pkg::ST_IDLE;
         endcase
      end
   end
   // long conversion owed after enable or after a reference change
   always_ff @(posedge I_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         need_long_ff <= 1'b1;
      end else if (wr_mux && bus.wdata[7:6] != mux_ff[7:6]) begin
         need_long_ff <= 1'b1; // RULE5
      end else if (launch) begin
         need_long_ff <= 1'b0; // paid by this launch; a change mid-run is kept
      end else if (!on_ff) begin
         need_long_ff <= 1'b1; // RULE11
      end
   end
   // active selection only moves when no conversion holds it
   always_ff @(posedge I_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         ref_act_ff <= 2'h0;
         ch_act_ff <= 4'h0;
      end else if (!busy) begin
         ref_act_ff <= mux_ff[acs_pkg::B_REF_HI:acs_pkg::B_REF_LO]; // RULE4
         ch_act_ff <= mux_ff[acs_pkg::B_CH_HI:0]; // RULE7
      end
   end
   // stub core samples at the last converter cycle
   always_ff @(posedge I_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         core_ff <= 10'h000;
      end else if (done) begin
         core_ff <= I_ANALOG_SAMPLE; // RULE24
      end
   end
   // result pair lock; low byte read freezes until high byte read
   always_ff @(posedge I_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         res_ff <= 10'h000;
         frozen_ff <= 1'b0;
      end else begin
         if (bus.rd && bus.addr == acs_pkg::OFS_RES_L) begin
            frozen_ff <= 1'b1; // RULE21
         end else if (bus.rd && bus.addr == acs_pkg::OFS_RES_H) begin
            frozen_ff <= 1'b0;
         end
         if (state_ff == acs_pkg::ST_DONE && !frozen_ff) begin
            res_ff <= core_ff;
         end
      end
   end
   // flag: completion set beats software or vector clear
   always_ff @(posedge I_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         flag_ff <= 1'b0;
      end else if (state_ff == acs_pkg::ST_DONE && !frozen_ff) begin
         flag_ff <= 1'b1; // RULE14
      end else if (bus.irq_ack || (wr_ctrl && bus.wdata[acs_pkg::B_FLAG])) begin
         flag_ff <= 1'b0; // RULE16
      end
   end
   // alignment applied at read time so it takes effect at once
   assign shown = ctrl_b_ff[acs_pkg::B_LEFT] ? {res_ff, 6'h00} : {6'h00, res_ff}; // RULE23
   // read mux; unmapped offsets read zero
   always_comb begin
      unique case (bus.addr)
         acs_pkg::OFS_CTRL: bus.rdata = {on_ff, busy, auto_ff, flag_ff, irq_on_ff, pre_ff}; // RULE12
         acs_pkg::OFS_MUX: bus.rdata = mux_ff;
         acs_pkg::OFS_CTRL_B: bus.rdata = ctrl_b_ff;
         acs_pkg::OFS_RES_H: bus.rdata = shown[15:8];
         acs_pkg::OFS_RES_L: bus.rdata = shown[7:0];
         default: bus.rdata = 8'h00;
      endcase
   end
   assign bus.irq = flag_ff && irq_on_ff && I_GLOBAL_IRQ_ON; // RULE15
   // analog selection outputs
   assign O_REF_SEL = ref_act_ff; // RULE3
   assign O_REF_PIN_CONNECT = ref_act_ff == acs_pkg::REF_EXT;
   assign O_CHANNEL_SEL = ch_act_ff; // RULE6
   assign O_CHANNEL_VALID = ch_act_ff <= acs_pkg::CH_TEMP;
   assign O_TEMP_SENSOR_ON = ch_act_ff == acs_pkg::CH_TEMP; // RULE1
   assign O_CONVERTER_POWERED = on_ff;
   assign O_BUSY = busy;
endmodule

/* logic/acs_host.sv */
// cpu-side driver issuing register accesses for the converter
`timescale 1ns/1ps
module acs_host (
   input wire logic I_CLK,
   input wire logic I_RST_B,
   acs_bus_if.host bus,
   input wire logic I_REQ,
   input wire logic I_WRITE,
   input wire logic [7:0] I_ADDR,
   input wire logic [7:0] I_WDATA,
   input wire logic I_IRQ_ACK,
   output logic [7:0] O_RDATA,
   output logic O_DONE,
   output logic O_IRQ,
   output logic O_REF_SETTLED
);
   logic [7:0] rdata_ff;
   logic done_ff;
   logic [14:0] settle_ff;
   // writes go as given, touch bits forced zero; no read-modify-write here
   assign bus.addr = I_ADDR;
   assign bus.wdata = (I_ADDR == acs_pkg::OFS_MUX) ? (I_WDATA & 8'hCF) : I_WDATA; // RULE8 RULE17
   assign bus.wr = I_REQ && I_WRITE;
   assign bus.rd = I_REQ && !I_WRITE;
   assign bus.irq_ack = I_IRQ_ACK;
   assign O_IRQ = bus.irq;
   // read data captured one cycle after request
   always_ff @(posedge I_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         rdata_ff <= 8'h00;
         done_ff <= 1'b0;
      end else begin
         done_ff <= I_REQ;
         if (bus.rd) begin
            rdata_ff <= bus.rdata;
         end
      end
   end
   assign O_RDATA = rdata_ff;
   assign O_DONE = done_ff;
   // settle timer restarts on internal reference write
   always_ff @(posedge I_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         settle_ff <= 15'h0000;
      end else if (bus.wr && I_ADDR == acs_pkg::OFS_MUX && I_WDATA[7:6] == acs_pkg::REF_INT) begin
         settle_ff <= 15'(acs_pkg::SETTLE_CYC); // RULE19
      end else if (settle_ff != 15'h0000) begin
         settle_ff <= settle_ff - 15'h0001;
      end
   end
   assign O_REF_SETTLED = settle_ff == 15'h0000;
endmodule

/* logic/acs_pkg.sv */
// shared constants and types for the converter control sequencer
package acs_pkg;
   // register offsets on the i/o register bus, and the registers' reset value
   localparam logic [7:0] OFS_CTRL = 8'h03;
   localparam logic [7:0] OFS_MUX = 8'h04;
   localparam logic [7:0] OFS_CTRL_B = 8'h02;
   localparam logic [7:0] OFS_RES_H = 8'h01;
   localparam logic [7:0] OFS_RES_L = 8'h00;
   localparam logic [7:0] RST_BYTE = 8'h00;
   // control register fields
   localparam int B_ON = 7;
   localparam int B_START = 6;
   localparam int B_AUTO = 5;
   localparam int B_FLAG = 4;
   localparam int B_IRQ_ON = 3;
   // control b register fields
   localparam int B_LEFT = 3;
   // mux register fields
   localparam int B_REF_HI = 7;
   localparam int B_REF_LO = 6;
   localparam int B_CH_HI = 3;
   // reference codes
   localparam logic [1:0] REF_SUPPLY = 2'h0;
   localparam logic [1:0] REF_EXT = 2'h1;
   localparam logic [1:0] REF_INT = 2'h2;
   // channel codes, and the free running trigger code
   localparam logic [3:0] CH_EXT_LAST = 4'hB;
   localparam logic [3:0] CH_GROUND = 4'hC;
   localparam logic [3:0] CH_BANDGAP = 4'hD;
   localparam logic [3:0] CH_TEMP = 4'hE;
   localparam logic [2:0] TRIG_FREE = 3'h0;
   // conversion lengths in converter clock cycles
   localparam logic [4:0] CYC_NORMAL = 5'h0D;
   localparam logic [4:0] CYC_LONG = 5'h19;
   // host side: settling wait after internal reference select
   localparam int SETTLE_US = 1000;
   localparam int CLK_MHZ = 25;
   localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_CONV = 2'b01,
      ST_DONE = 2'b11
   } acs_state_t;
endpackage

/* logic/acs_prescaler.sv */
// converter clock enable divider selected by the prescaler field
`timescale 1ns/1ps
module acs_prescaler (
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_run,
   input wire logic [2:0] i_sel,
   output logic o_tick
);
   logic [6:0] cnt_ff;
   logic [6:0] last;
   // codes 0 and 1 both divide by two
   always_comb begin
      last = 7'h01;
      if (i_sel > 3'h1) begin
         last = 7'((8'h01 << i_sel) - 8'h01); // RULE18
      end
   end
   // counter held at zero while off so the first tick is a full period
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         cnt_ff <= 7'h00;
      end else if (!i_run || cnt_ff >= last) begin
         cnt_ff <= 7'h00;
      end else begin
         cnt_ff <= cnt_ff + 7'h01;
      end
   end
   assign o_tick = i_run && (cnt_ff >= last);
endmodule

/* tb/acs_props.sv */
// bus-level checker for the converter control sequencer
`timescale 1ns/1ps
module acs_props (
   input wire logic I_CLK,
   input wire logic I_RST_B,
   input wire logic I_GLOBAL_IRQ_ON,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [7:0] rdata,
   input wire logic irq,
   input wire logic irq_ack
);
   logic [7:0] mux_ff;
   logic [7:0] ctl_ff;
   // last written mux value; reset matches the register's zero default
   always_ff @(posedge I_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         mux_ff <= acs_pkg::RST_BYTE;
      end else if (wr && addr == acs_pkg::OFS_MUX) begin
         mux_ff <= wdata;
      end
   end
   // last written control value; only plain read/write bits are compared
   always_ff @(posedge I_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         ctl_ff <= acs_pkg::RST_BYTE;
      end else if (wr && addr == acs_pkg::OFS_CTRL) begin
         ctl_ff <= wdata;
      end
   end
   default clocking @(posedge I_CLK); endclocking
   default disable iff (!I_RST_B);
   sequence s_rd_ctl;
      rd && addr == acs_pkg::OFS_CTRL;
   endsequence
   sequence s_go;
      wr && addr == acs_pkg::OFS_CTRL && wdata[acs_pkg::B_ON] && wdata[acs_pkg::B_START];
   endsequence
   sequence s_off;
      wr && addr == acs_pkg::OFS_CTRL && !wdata[acs_pkg::B_ON];
   endsequence
   sequence s_w1c;
      wr && addr == acs_pkg::OFS_CTRL && wdata[acs_pkg::B_FLAG];
   endsequence
   property p_unmapped;
      rd && addr > acs_pkg::OFS_MUX |-> rdata == 8'h00;
   endproperty
   property p_mux_rw;
      rd && addr == acs_pkg::OFS_MUX |-> rdata == mux_ff;
   endproperty
   property p_ctl_rw;
      s_rd_ctl |-> (rdata & 8'hAF) == (ctl_ff & 8'hAF);
   endproperty
   property p_start_busy;
      s_go ##[1:6] s_rd_ctl |-> rdata[acs_pkg::B_START];
   endproperty
   property p_off_abort;
      s_off ##[1:6] s_rd_ctl |-> !rdata[acs_pkg::B_START];
   endproperty
   property p_flag_w1c;
      s_w1c ##[1:6] s_rd_ctl |-> !rdata[acs_pkg::B_FLAG];
   endproperty
   property p_irq;
      irq |-> I_GLOBAL_IRQ_ON && (!(rd && addr == acs_pkg::OFS_CTRL)
         || (rdata[acs_pkg::B_FLAG] && rdata[acs_pkg::B_IRQ_ON]));
   endproperty
   property p_ack;
      irq_ack |=> !irq;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   a_mux_rw: assert property (p_mux_rw) else $error("mux readback wrong");
   a_ctl_rw: assert property (p_ctl_rw) else $error("control readback wrong");
   a_start_busy: assert property (p_start_busy) else $error("start not busy");
   a_off_abort: assert property (p_off_abort) else $error("disable kept busy");
   a_flag_w1c: assert property (p_flag_w1c) else $error("flag not cleared");
   a_irq: assert property (p_irq) else $error("irq without cause");
   a_ack: assert property (p_ack) else $error("irq after vector");
endmodule

/* tb/acs_test.sv */
// self-checking bench: cpu-side driver facing the converter control
`timescale 1ns/1ps
module acs_test;
   logic clk, rst_b, req, wrt, ack, gie, trig, done, irq, settled, refc, chv, tson, pwr, busy;
   logic [7:0] adr, wd, rdat;
   logic [9:0] smp;
   logic [1:0] refs;
   logic [3:0] chs;
   int miscompares = 0;
   int compares = 0;
   acs_bus_if bus();
   acs_host i_acs_host (.I_CLK(clk), .I_RST_B(rst_b), .bus(bus), .I_REQ(req), .I_WRITE(wrt),
      .I_ADDR(adr), .I_WDATA(wd), .I_IRQ_ACK(ack), .O_RDATA(rdat), .O_DONE(done),
      .O_IRQ(irq), .O_REF_SETTLED(settled));
   acs_device i_acs_device (.I_CLK(clk), .I_RST_B(rst_b), .bus(bus), .I_GLOBAL_IRQ_ON(gie),
      .I_TRIGGER(trig), .I_ANALOG_SAMPLE(smp), .O_REF_SEL(refs), .O_REF_PIN_CONNECT(refc),
      .O_CHANNEL_SEL(chs), .O_CHANNEL_VALID(chv), .O_TEMP_SENSOR_ON(tson),
      .O_CONVERTER_POWERED(pwr), .O_BUSY(busy));
   acs_props i_acs_props (.I_CLK(clk), .I_RST_B(rst_b), .I_GLOBAL_IRQ_ON(gie),
      .addr(bus.addr), .wdata(bus.wdata), .wr(bus.wr), .rd(bus.rd), .rdata(bus.rdata),
      .irq(bus.irq), .irq_ack(bus.irq_ack));
   // 25 MHz system clock
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic finish_test();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
      compares++;
      if (s !== e) begin
         miscompares++;
         $display("unexpected %s: expected %h seen %h", n, e, s);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) begin
         @(posedge clk);
         #1;
      end
   endtask
   // one-cycle request, bounded wait for done, one idle edge so req never toggles twice
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
      int i;
      req = 1'b1;
      wrt = w;
      adr = a;
      wd = d;
      tick(1);
      req = 1'b0;
      for (i = 0; i < 8 && done !== 1'b1; i++) tick(1);
      if (i == 8) begin
         miscompares++;
         finish_test();
      end
      tick(1);
   endtask
   task automatic wctl(input logic [7:0] d);
      acc(1'b1, acs_pkg::OFS_CTRL, d);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string n);
      acc(1'b0, a, 8'h00);
      chk(n, 16'(rdat), 16'(e));
   endtask
   // waits out a conversion; length allows for cycles already spent in the access
   task automatic conv(input int t, input int dv);
      int n;
      for (n = 0; n < 4000 && busy === 1'b1; n++) tick(1);
      chk("conv_len", 16'(n >= t * dv - dv - 10 && n <= t * dv), 16'h0001);
      if (n == 4000) finish_test();
      tick(3);
   endtask
   initial begin
      int i;
      {rst_b, req, wrt, ack, gie, trig, adr, wd} = '0;
      smp = 10'h2A5;
      repeat (10) @(posedge clk);
      #1 rst_b = 1'b1;
      for (i = 0; i < 8; i++) rdc(8'(i), 8'h00, "reset_read");
      chk("settled_idle", 16'(settled), 16'h0001);
      $display("test reset done");
      for (i = 0; i < 16; i++) begin
         acc(1'b1, acs_pkg::OFS_MUX, {2'(i % 3), 2'b00, 4'(i)});
         chk("ref_sel", 16'(refs), 16'(i % 3));
         if (i % 3 != 2) chk("ref_pin", 16'(refc), 16'(i % 3 == 1));
         chk("chan_sel", 16'(chs), 16'(i));
         chk("chan_valid", 16'(chv), 16'(i != 15));
         chk("temp_on", 16'(tson), 16'(i == 14));
      end
      $display("test decode done");
      for (i = 0; i < 8; i++) begin
         wctl(8'h00);
         wctl(8'hC0 | 8'(i));
         conv(25, i < 2 ? 2 : 1 << i);
         wctl(8'hD0 | 8'(i));
         conv(13, i < 2 ? 2 : 1 << i);
      end
      rdc(acs_pkg::OFS_CTRL, 8'h97, "ctrl_done");
      rdc(acs_pkg::OFS_RES_L, 8'hA5, "res_low");
      rdc(acs_pkg::OFS_RES_H, 8'h02, "res_high");
      acc(1'b1, acs_pkg::OFS_CTRL_B, 8'h08);
      rdc(acs_pkg::OFS_RES_L, 8'h40, "left_low");
      rdc(acs_pkg::OFS_RES_H, 8'hA9, "left_high");
      acc(1'b1, acs_pkg::OFS_CTRL_B, 8'h00);
      $display("test prescale done");
      gie = 1'b1;
      wctl(8'h81);
      chk("irq_masked", 16'(irq), 16'h0000);
      wctl(8'h89);
      chk("irq_on", 16'(irq), 16'h0001);
      gie = 1'b0;
      tick(1);
      chk("irq_global", 16'(irq), 16'h0000);
      gie = 1'b1;
      ack = 1'b1;
      tick(1);
      ack = 1'b0;
      tick(2);
      chk("irq_vector", 16'(irq), 16'h0000);
      rdc(acs_pkg::OFS_CTRL, 8'h89, "flag_vector");
      wctl(8'hC9);
      conv(13, 2);
      rdc(acs_pkg::OFS_CTRL, 8'h99, "flag_set");
      wctl(8'h99);
      rdc(acs_pkg::OFS_CTRL, 8'h89, "flag_w1c");
      $display("test interrupt done");
      wctl(8'hC1);
      acc(1'b1, acs_pkg::OFS_MUX, 8'h8E);
      chk("settle_wait", 16'(settled), 16'h0000);
      chk("ref_hold", 16'(refs), 16'h0000);
      chk("chan_hold", 16'(chs), 16'h000F);
      conv(13, 2);
      chk("ref_new", 16'(refs), 16'h0002);
      chk("chan_new", 16'(chs), 16'h000E);
      rdc(acs_pkg::OFS_MUX, 8'h8E, "mux_read");
      wctl(8'hD1);
      conv(25, 2);
      wctl(8'hD1);
      conv(13, 2);
      $display("test mux change done");
      wctl(8'hD1);
      rdc(acs_pkg::OFS_CTRL, 8'hC1, "busy_read");
      wctl(8'h81);
      chk("start_zero", 16'(busy), 16'h0001);
      wctl(8'h01);
      chk("abort", 16'({busy, pwr}), 16'h0000);
      rdc(acs_pkg::OFS_CTRL, 8'h01, "abort_read");
      wctl(8'h41);
      chk("start_off", 16'(busy), 16'h0000);
      $display("test abort done");
      acc(1'b1, acs_pkg::OFS_CTRL_B, 8'h01);
      wctl(8'hA1);
      trig = 1'b1;
      tick(6);
      chk("trig_start", 16'(busy), 16'h0001);
      conv(25, 2);
      trig = 1'b0;
      acc(1'b1, acs_pkg::OFS_CTRL_B, 8'h00);
      tick(4);
      chk("free_no_edge", 16'(busy), 16'h0000);
      wctl(8'hF1);
      conv(13, 2);
      chk("free_rerun", 16'(busy), 16'h0001);
      wctl(8'h00);
      $display("test trigger done");
      smp = 10'h15A;
      wctl(8'hC1);
      conv(25, 2);
      rdc(acs_pkg::OFS_RES_L, 8'h5A, "low_new");
      smp = 10'h3C3;
      wctl(8'hD1);
      conv(13, 2);
      rdc(acs_pkg::OFS_RES_H, 8'h01, "high_frozen");
      $display("test freeze done");
      finish_test();
   end
endmodule
